// ===== pkg/idp_pkg.sv
`default_nettype none
package idp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] IDP_OPC_LEGACY = 8'h90;
  localparam logic [7:0] IDP_OPC_IDTAB  = 8'h9f;
  localparam logic [7:0] IDP_OPC_SIG    = 8'hab;
  localparam logic [7:0] IDP_OPC_SFDP   = 8'h5a;

  ////////////////////////////////////////////////////////////////////////////
  // phase lengths in serial clock cycles
  localparam logic [4:0] IDP_OPC_BITS        = 5'h08;
  localparam logic [4:0] IDP_ADDR_BITS       = 5'h18;
  localparam logic [4:0] IDP_SIG_DUMMY_BITS  = 5'h18;
  localparam logic [4:0] IDP_SFDP_DUMMY_BITS = 5'h08;

  ////////////////////////////////////////////////////////////////////////////
  // address and table layout
  localparam logic [23:0] IDP_ADDR_SWAP  = 24'h000001;
  localparam int          IDP_ID_BYTES   = 16;
  localparam int          IDP_SFDP_BYTES = 16;
  localparam int          IDP_IDX_W      = 4;
  localparam logic [7:0]  IDP_ID_END     = 8'h10;
  localparam logic [7:0]  IDP_UNDEF_BYTE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [4:0]  IDP_RST_CNT  = 5'h00;
  localparam logic [23:0] IDP_RST_ADDR = 24'h000000;
  localparam logic [6:0]  IDP_RST_SH   = 7'h00;
  localparam logic [7:0]  IDP_RST_BYTE = 8'h00;
  localparam logic [2:0]  IDP_RST_BIT  = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // table contents, all values arbitrary
  localparam logic [7:0] IDP_ID_INIT [IDP_ID_BYTES] = '{
    8'h00, 8'h00, 8'h00, 8'h4d, 8'h80, 8'h51, 8'h52, 8'h59,
    8'h02, 8'h00, 8'h40, 8'h00, 8'h53, 8'h46, 8'h51, 8'h00};
  localparam logic [7:0] IDP_SFDP_INIT [IDP_SFDP_BYTES] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01, 8'hff,
    8'h00, 8'h06, 8'h01, 8'h10, 8'h08, 8'h00, 8'h00, 8'hff};

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE
  } idp_state_e;

  typedef enum logic [1:0] {
    CMD_LEGACY, CMD_IDTAB, CMD_SIG, CMD_SFDP
  } idp_cmd_e;

  typedef struct packed {
    logic cs_n;
    logic si;
  } idp_spi_s;

  typedef struct packed {
    logic data;
    logic oe;
  } idp_so_s;

endpackage : idp_pkg
`default_nettype wire

// ===== design/idp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module idp_sync
  import idp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : idp_sync
`default_nettype wire

// ===== design/idp_top.sv
// Summary of operation
// - legacy id read is opcode 90h then a 24-bit address.
// - legacy id bytes go out msb first from falling edge after address.
// - address 000001h sends device code first, maker code second.
// - legacy id read keeps alternating the two codes until deselect.
// - id table read is ignored while a program or erase runs.
// - id table read streams maker, device, extended id, parameters after opcode.
// - clocking past the id table end gives undefined data.
// - host may end the id table read anytime; output stops.
// - signature read is opcode abh, three dummy bytes, then signature byte.
// - signature byte repeats every further eight clocks.
// - host may end the signature read anytime; output is released.
// - parameter read is 5ah, 24-bit address, eight dummies, then bytes.
// - parameter read address picks the starting byte.
// - reserved and unknown opcodes are taken without any action.
`timescale 1ns/100ps
`default_nettype none
module idp_top
  import idp_pkg::*;
#(
  parameter logic [7:0] MAKER_ID   = 8'ha5,  // arbitrary
  parameter logic [7:0] DEVICE_ID  = 8'h3c,  // arbitrary
  parameter logic [7:0] DEVICE_ID2 = 8'h7e,  // arbitrary
  parameter logic [7:0] SIG_ID     = 8'h3c   // arbitrary
) (
  input  wire logic     clock,
  input  wire logic     rst,
  input  wire logic     sck,
  input  wire idp_spi_s spi_i,
  input  wire logic     busy_i,
  output var  idp_so_s  so_o,
  output var  logic     id_cmd_pulse_o
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic       sck_rst;
  idp_state_e st_q;
  idp_state_e st_d;
  idp_cmd_e   cmd_q;
  idp_cmd_e   cmd_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [6:0] sh_q;
  logic [23:0] addr_q;
  logic [23:0] addr_d;
  logic [7:0] op_byte;
  logic       phase_end;
  logic       busy_s;
  logic       evt_q;
  logic       evt_s;
  logic       evt_seen_q;
  logic       pulse_q;
  logic [2:0] out_bit_q;
  logic [7:0] byte_cnt_q;
  idp_so_s    so_q;
  logic [7:0] legacy_byte;
  logic [7:0] id_byte;
  logic [7:0] sfdp_byte;
  logic [7:0] byte_val;
  logic [IDP_IDX_W-1:0] sfdp_idx;
  logic [7:0] id_mem   [IDP_ID_BYTES];
  logic [7:0] sfdp_mem [IDP_SFDP_BYTES];

  function automatic logic [4:0] phase_len(idp_state_e st, idp_cmd_e c);
    logic [4:0] len;
    len = IDP_OPC_BITS;
    case (st)
      ST_OPC:   len = IDP_OPC_BITS;
      ST_ADDR:  len = IDP_ADDR_BITS;
      ST_DUMMY: len = (c == CMD_SIG) ? IDP_SIG_DUMMY_BITS : IDP_SFDP_DUMMY_BITS;
      default:  len = IDP_OPC_BITS;
    endcase
    return len;
  endfunction : phase_len

  //////////////////////////////////////////////////////////////////////////////
  // tables

  assign id_mem[0] = MAKER_ID;
  assign id_mem[1] = DEVICE_ID;
  assign id_mem[2] = DEVICE_ID2;

  for (genvar gi = 3; gi < IDP_ID_BYTES; gi++) begin : g_id
    assign id_mem[gi] = IDP_ID_INIT[gi];
  end

  for (genvar gs = 0; gs < IDP_SFDP_BYTES; gs++) begin : g_sfdp
    assign sfdp_mem[gs] = IDP_SFDP_INIT[gs];
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame decode, rising edge of the serial clock

  // deselect holds the frame decode and serial output in reset
  assign sck_rst   = rst | spi_i.cs_n;
  assign op_byte   = {sh_q, spi_i.si};
  assign phase_end = (cnt_q == 5'(phase_len(st_q, cmd_q) - 5'h01));

  always_comb begin
    st_d  = st_q;
    cmd_d = cmd_q;
    case (st_q)
      ST_OPC: begin
        if (phase_end) begin
          case (op_byte)
            IDP_OPC_LEGACY: begin
              st_d  = ST_ADDR;
              cmd_d = CMD_LEGACY;
            end
            IDP_OPC_IDTAB: begin
              st_d  = busy_s ? ST_IGNORE : ST_DATA;
              cmd_d = CMD_IDTAB;
            end
            IDP_OPC_SIG: begin
              st_d  = ST_DUMMY;
              cmd_d = CMD_SIG;
            end
            IDP_OPC_SFDP: begin
              st_d  = ST_ADDR;
              cmd_d = CMD_SFDP;
            end
            default: st_d = ST_IGNORE;
          endcase
        end
      end
      ST_ADDR: begin
        if (phase_end) begin
          st_d = (cmd_q == CMD_SFDP) ? ST_DUMMY : ST_DATA;
        end
      end
      ST_DUMMY: begin
        if (phase_end) begin
          st_d = ST_DATA;
        end
      end
      default: st_d = st_q;
    endcase
  end

  assign cnt_d  = (st_q == ST_DATA || st_q == ST_IGNORE) ? cnt_q :
                  phase_end ? IDP_RST_CNT : 5'(cnt_q + 5'h01);
  assign addr_d = (st_q == ST_ADDR) ? {addr_q[22:0], spi_i.si} : addr_q;

  always_ff @(posedge sck or posedge sck_rst) begin
    if (sck_rst) begin
      st_q   <= ST_OPC;
      cmd_q  <= CMD_LEGACY;
      cnt_q  <= IDP_RST_CNT;
      sh_q   <= IDP_RST_SH;
      addr_q <= IDP_RST_ADDR;
    end else begin
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      cnt_q  <= cnt_d;
      sh_q   <= op_byte[6:0];
      addr_q <= addr_d;
    end
  end

  // event toggle survives deselect, only the system reset clears it
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= evt_q ^ (st_q == ST_OPC && phase_end && st_d != ST_IGNORE);
    end
  end

  idp_sync #(.W(1)) u_busy_sync (
    .clock (sck),
    .rst   (rst),
    .d     (busy_i),
    .q     (busy_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // output byte selection

  assign legacy_byte = (addr_q[0] ^ byte_cnt_q[0]) ? DEVICE_ID : MAKER_ID;
  assign id_byte     = (byte_cnt_q < IDP_ID_END) ?
                       id_mem[byte_cnt_q[IDP_IDX_W-1:0]] : IDP_UNDEF_BYTE;
  assign sfdp_idx    = IDP_IDX_W'(addr_q[IDP_IDX_W-1:0] +
                                  byte_cnt_q[IDP_IDX_W-1:0]);
  assign sfdp_byte   = sfdp_mem[sfdp_idx];
  assign byte_val    = (cmd_q == CMD_LEGACY) ? legacy_byte :
                       (cmd_q == CMD_IDTAB)  ? id_byte :
                       (cmd_q == CMD_SIG)    ? SIG_ID : sfdp_byte;

  //////////////////////////////////////////////////////////////////////////////
  // serial output, falling edge of the serial clock

  always_ff @(negedge sck or posedge sck_rst) begin
    if (sck_rst) begin
      so_q       <= '0;
      out_bit_q  <= IDP_RST_BIT;
      byte_cnt_q <= IDP_RST_BYTE;
    end else if (st_q == ST_DATA) begin
      so_q.data  <= byte_val[3'h7 - out_bit_q];
      so_q.oe    <= 1'b1;
      out_bit_q  <= 3'(out_bit_q + 3'h1);
      byte_cnt_q <= (out_bit_q == 3'h7) ? 8'(byte_cnt_q + 8'h01) : byte_cnt_q;
    end else begin
      so_q <= '0;
    end
  end

  assign so_o = so_q;

  //////////////////////////////////////////////////////////////////////////////
  // command event into the system clock domain

  idp_sync #(.W(1)) u_evt_sync (
    .clock (clock),
    .rst   (rst),
    .d     (evt_q),
    .q     (evt_s)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt_seen_q <= 1'b0;
      pulse_q    <= 1'b0;
    end else begin
      evt_seen_q <= evt_s;
      pulse_q    <= evt_s ^ evt_seen_q;
    end
  end

  assign id_cmd_pulse_o = pulse_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  property p_legacy_opc;
    @(posedge sck) disable iff (sck_rst)
      (st_q == ST_OPC && phase_end && op_byte == IDP_OPC_LEGACY)
      |=> (st_q == ST_ADDR && cmd_q == CMD_LEGACY) ##23 (st_q == ST_ADDR)
          ##1 (st_q == ST_DATA);
  endproperty
  a_legacy_opc: assert property (p_legacy_opc)
    else $error("legacy id read did not take a 24-bit address");

  // first fall after the address already sent bit 0
  sequence s_enter_data;
    (st_q == ST_DATA && so_q.oe && byte_cnt_q == 8'h00 && out_bit_q == 3'h1)
      ##1 (so_q.oe && out_bit_q == 3'h2);
  endsequence

  property p_legacy_out;
    @(posedge sck) disable iff (sck_rst)
      (st_q == ST_ADDR && phase_end && cmd_q == CMD_LEGACY) |=> s_enter_data;
  endproperty
  a_legacy_out: assert property (p_legacy_out)
    else $error("legacy id output did not start after the address");

  property p_legacy_swap;
    @(negedge sck) disable iff (sck_rst)
      (st_q == ST_DATA && cmd_q == CMD_LEGACY && addr_q == IDP_ADDR_SWAP &&
       byte_cnt_q == 8'h00 && out_bit_q == 3'h0) |=> (so_q.data == DEVICE_ID[7]);
  endproperty
  a_legacy_swap: assert property (p_legacy_swap)
    else $error("swapped legacy id did not send the device code first");

  property p_legacy_alt;
    @(negedge sck) disable iff (sck_rst)
      (st_q == ST_DATA && cmd_q == CMD_LEGACY && out_bit_q == 3'h7)
      |=> (byte_val != $past(byte_val)) || (MAKER_ID == DEVICE_ID);
  endproperty
  a_legacy_alt: assert property (p_legacy_alt)
    else $error("legacy id bytes did not alternate");

  property p_busy_ignore;
    @(posedge sck) disable iff (sck_rst)
      (st_q == ST_OPC && phase_end && op_byte == IDP_OPC_IDTAB && busy_s)
      |=> (st_q == ST_IGNORE && !so_q.oe) [*4];
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("id table read answered while busy");

  property p_idtab_out;
    @(negedge sck) disable iff (sck_rst)
      (st_q == ST_DATA && cmd_q == CMD_IDTAB && out_bit_q == 3'h0 &&
       byte_cnt_q < IDP_ID_END) |=> (so_q.data == $past(id_byte[7]) && so_q.oe);
  endproperty
  a_idtab_out: assert property (p_idtab_out)
    else $error("id table byte sent out of sequence");

  property p_sig_dummy;
    @(posedge sck) disable iff (sck_rst)
      (st_q == ST_OPC && phase_end && op_byte == IDP_OPC_SIG)
      |=> (st_q == ST_DUMMY) ##23 (st_q == ST_DUMMY) ##1 (st_q == ST_DATA);
  endproperty
  a_sig_dummy: assert property (p_sig_dummy)
    else $error("signature read did not wait three dummy bytes");

  property p_sig_repeat;
    @(negedge sck) disable iff (sck_rst)
      (st_q == ST_DATA && cmd_q == CMD_SIG && out_bit_q == 3'h0)
      |=> (so_q.data == SIG_ID[7]) ##7 (so_q.data == SIG_ID[0]);
  endproperty
  a_sig_repeat: assert property (p_sig_repeat)
    else $error("signature byte not repeated");

  property p_sfdp_seq;
    @(posedge sck) disable iff (sck_rst)
      (st_q == ST_OPC && phase_end && op_byte == IDP_OPC_SFDP)
      |=> (st_q == ST_ADDR) ##23 (st_q == ST_ADDR) ##1 (st_q == ST_DUMMY) [*8]
          ##1 (st_q == ST_DATA);
  endproperty
  a_sfdp_seq: assert property (p_sfdp_seq)
    else $error("parameter read phases out of order");

  property p_sfdp_start;
    @(negedge sck) disable iff (sck_rst)
      (st_q == ST_DATA && cmd_q == CMD_SFDP && byte_cnt_q == 8'h00 &&
       out_bit_q == 3'h0)
      |=> (so_q.data == sfdp_mem[addr_q[IDP_IDX_W-1:0]][7]);
  endproperty
  a_sfdp_start: assert property (p_sfdp_start)
    else $error("parameter read started at the wrong byte");

  // serial clock is stopped while deselected, so watch on the system clock
  property p_off_deselect;
    @(posedge clock) disable iff (rst)
      spi_i.cs_n |-> !so_q.oe;
  endproperty
  a_off_deselect: assert property (p_off_deselect)
    else $error("output driven while deselected");

endmodule : idp_top
`default_nettype wire

// ===== tb/idp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module idp_host_model
  import idp_pkg::*;
(
  output var  logic     sck,
  output var  idp_spi_s spi_o,
  input  wire idp_so_s  so_i
);

  ////////////////////////////////////////////////////////////////////////////
  // serial clock idles low between frames, 48 ns period inside
  initial begin
    sck   = 1'b0;
    spi_o = '{cs_n: 1'b1, si: 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame: opcode, address or dummies msb first, then nbits read back
  task automatic frame(input  logic [39:0] tx,
                       input  int          nin,
                       input  int          nbits,
                       output logic        q[$],
                       output logic        oe_any,
                       output logic        early);
    q      = {};
    oe_any = 1'b0;
    early  = 1'b0;
    spi_o.cs_n = 1'b0;
    for (int i = 0; i < nin; i++) begin
      spi_o.si = tx[39-i];
      #24 sck = 1'b1;
      early = early | so_i.oe;
      #24 sck = 1'b0;
    end
    for (int i = 0; i < nbits; i++) begin
      spi_o.si = ~spi_o.si;
      #24 sck = 1'b1;
      q.push_back(so_i.oe ? so_i.data : 1'bx);
      oe_any = oe_any | so_i.oe;
      #24 sck = 1'b0;
    end
    #20 spi_o.cs_n = 1'b1;
    spi_o.si = ~spi_o.si;
  endtask : frame

endmodule : idp_host_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import idp_pkg::*;

  localparam logic [7:0] MAKER = 8'ha5;  // arbitrary
  localparam logic [7:0] DEV   = 8'h3c;  // arbitrary
  localparam logic [7:0] DEV2  = 8'h7e;  // arbitrary
  localparam logic [7:0] SIG   = 8'h3c;  // arbitrary

  logic        clock;
  logic        rst;
  logic        sck;
  logic        busy_i;
  logic        id_cmd_pulse_o;
  idp_spi_s    spi_i;
  idp_so_s     so_o;
  int          err_total;
  int          checks;
  int          pulses;
  int          seed;
  int          n;
  logic        q[$];
  logic        oe_any;
  logic        early;
  logic [23:0] a24;
  logic [7:0]  o;

  ////////////////////////////////////////////////////////////////////////////
  idp_top #(.MAKER_ID(MAKER), .DEVICE_ID(DEV), .DEVICE_ID2(DEV2), .SIG_ID(SIG)) u_idp_top (
    .clock          (clock),
    .rst            (rst),
    .sck            (sck),
    .spi_i          (spi_i),
    .busy_i         (busy_i),
    .so_o           (so_o),
    .id_cmd_pulse_o (id_cmd_pulse_o)
  );

  idp_host_model u_idp_host_model (
    .sck   (sck),
    .spi_o (spi_i),
    .so_i  (so_o)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (id_cmd_pulse_o === 1'b1) pulses++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report(input string msg);
    err_total++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : report

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) report(msg);
  endtask : cmp_byte

  task automatic cmp_flag(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) report(msg);
  endtask : cmp_flag

  task automatic cmp_cnt(input int got, input int exp, input string msg);
    checks++;
    if (got != exp) report(msg);
  endtask : cmp_cnt

  task automatic end_of_test;
    $display("err_total=%0d checks=%0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] byte_of(input int idx);
    logic [7:0] b;
    for (int j = 0; j < 8; j++) b[7-j] = q[idx*8+j];
    return b;
  endfunction : byte_of

  function automatic logic [7:0] exp_legacy(input logic a0, input int i);
    return ((i % 2 == 1) ^ a0) ? DEV : MAKER;
  endfunction : exp_legacy

  function automatic logic [7:0] exp_idtab(input int i);
    if (i == 0) return MAKER;
    if (i == 1) return DEV;
    if (i == 2) return DEV2;
    if (i < IDP_ID_BYTES) return IDP_ID_INIT[i];
    return IDP_UNDEF_BYTE;
  endfunction : exp_idtab

  function automatic logic [7:0] exp_sfdp(input logic [3:0] a, input int i);
    return IDP_SFDP_INIT[(int'(a) + i) % IDP_SFDP_BYTES];
  endfunction : exp_sfdp

  // frame, then deselect and pulse bookkeeping
  task automatic run(input logic [39:0] tx, input int nin, input int nbits, input int exp_p);
    int p0;
    p0 = pulses;
    u_idp_host_model.frame(tx, nin, nbits, q, oe_any, early);
    #1;
    cmp_flag(so_o.oe, 1'b0, "output on after deselect");
    cmp_flag(early, 1'b0, "output on during command");
    repeat (8) @(posedge clock);
    cmp_cnt(pulses - p0, exp_p, "command pulse count");
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    report("timeout");
    end_of_test;
  end

  initial begin
    err_total = 0;
    checks    = 0;
    pulses    = 0;
    seed      = 32'h33e6;
    rst       = 1'b1;
    busy_i    = 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    repeat (4) @(posedge clock);
    for (int a = 0; a < 2; a++) begin
      run({IDP_OPC_LEGACY, 23'h0, a[0], 8'h00}, 32, 40, 1);
      for (int i = 0; i < 5; i++) cmp_byte(byte_of(i), exp_legacy(a[0], i), "legacy id");
    end
    n = 17 + ($unsigned($random(seed)) % 4);
    run({IDP_OPC_IDTAB, 32'h0}, 8, n * 8, 1);
    for (int i = 0; i < n; i++) cmp_byte(byte_of(i), exp_idtab(i), "id table");
    @(negedge clock) busy_i = 1'b1;
    run({IDP_OPC_IDTAB, 32'h0}, 8, 16, 0);
    cmp_flag(oe_any, 1'b0, "id table answered while busy");
    @(negedge clock) busy_i = 1'b0;
    a24 = 24'($random(seed));
    run({IDP_OPC_SIG, a24, 8'h00}, 32, 24, 1);
    for (int i = 0; i < 3; i++) cmp_byte(byte_of(i), SIG, "signature");
    for (int k = 0; k < 5; k++) begin
      a24 = (k == 0) ? 24'h000000 : 24'($random(seed));
      run({IDP_OPC_SFDP, a24, 8'h00}, 40, 32, 1);
      for (int i = 0; i < 4; i++) cmp_byte(byte_of(i), exp_sfdp(a24[3:0], i), "param");
    end
    // aborts in mid byte
    run({IDP_OPC_IDTAB, 32'h0}, 8, 3, 1);
    cmp_byte({q[0], q[1], q[2], 5'h00}, {MAKER[7:5], 5'h00}, "aborted id table");
    run({IDP_OPC_SIG, 32'h0}, 32, 5, 1);
    cmp_byte({q[0], q[1], q[2], q[3], q[4], 3'h0}, {SIG[7:3], 3'h0}, "aborted sig");
    // reserved and unknown opcodes
    for (int k = 0; k < 6; k++) begin
      o = (k == 0) ? 8'ha3 : (k == 1) ? 8'h18 : (k == 2) ? 8'he6 : 8'($random(seed));
      if (o == IDP_OPC_LEGACY || o == IDP_OPC_IDTAB || o == IDP_OPC_SIG || o == IDP_OPC_SFDP) begin
        o = o ^ 8'h01;
      end
      run({o, 32'h0}, 8, 16, 0);
      cmp_flag(oe_any, 1'b0, "reserved opcode answered");
    end
    end_of_test;
  end

endmodule : tb_top
`default_nettype wire
